// File: core/vecm_defines.svh
// Register map, field positions and reset values of the detector
// Assumes inclusion by bare name from the core and the bench
`ifndef VECM_DEFINES_SVH
`define VECM_DEFINES_SVH
`define ADDR_CFG 8'h69
`define ADDR_THS_HI 8'h6A
`define ADDR_THS_LO 8'h6B
`define ADDR_CNT 8'h6C
`define ADDR_INITX_HI 8'h6D
`define ADDR_INITX_LO 8'h6E
`define ADDR_INITY_HI 8'h6F
`define ADDR_INITY_LO 8'h70
`define ADDR_INITZ_HI 8'h71
`define ADDR_INITZ_LO 8'h72
`define ADDR_INT_SRC 8'h5E
`define ADDR_HYBRID 8'h80
`define CFG_ELE 6
`define CFG_INITM 5
`define CFG_UPDM 4
`define CFG_EN 3
`define CFG_WAKE 2
`define CFG_INTEN 1
`define CFG_ROUTE 0
`define THS_DBCNTM 7
`define SRC_VECM 1
`define RST_BYTE 8'h00
`endif

// File: core/vecm_pkg.sv
// Types shared by the detector core
// Assumes the defines header sits beside it
package vecm_pkg;
    typedef logic [7:0] byte_t;
    typedef logic signed [15:0] axis_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SEQ} dphase_t;
endpackage : vecm_pkg

// File: core/vecm_detector.sv
// Magnetic vector-magnitude change detector with AHB-Lite registers
// Assumes samples arrive on CLK_SYS_I with a one-cycle valid strobe
`timescale 1ns/1ns
`default_nettype none
`include "vecm_defines.svh"
module vecm_detector
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic SAMPLE_VALID_I,
    input wire vecm_pkg::axis_t MAG_X_I,
    input wire vecm_pkg::axis_t MAG_Y_I,
    input wire vecm_pkg::axis_t MAG_Z_I,
    output logic IRQ_PIN_ONE_O,
    output logic IRQ_PIN_TWO_O,
    output logic WAKE_ACTIVITY_O
);
    import vecm_pkg::*;

    // ****************************************
    // Register bus
    // ****************************************
    byte_t cfg_ff, ths_hi_ff, ths_lo_ff, cnt_ff;
    byte_t ix_hi_ff, ix_lo_ff, iy_hi_ff, iy_lo_ff, iz_hi_ff, iz_lo_ff;
    logic hybrid_ff;
    logic flag_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] rdata_ff;
    logic src_read;
    logic [7:0] ap_addr;
    logic ap_valid;
    byte_t wb;
    byte_t rd_val;

    assign ap_valid = HSEL_I && HREADY_I && HTRANS_I[1];
    assign ap_addr = HADDR_I[9:2];
    assign wb = HWDATA_I[7:0];
    assign src_read = ap_valid && !HWRITE_I && ap_addr == `ADDR_INT_SRC;

    always_comb
    begin
        case (ap_addr)
            `ADDR_CFG: rd_val = cfg_ff;
            `ADDR_THS_HI: rd_val = ths_hi_ff;
            `ADDR_THS_LO: rd_val = ths_lo_ff;
            `ADDR_CNT: rd_val = cnt_ff;
            `ADDR_INITX_HI: rd_val = ix_hi_ff;
            `ADDR_INITX_LO: rd_val = ix_lo_ff;
            `ADDR_INITY_HI: rd_val = iy_hi_ff;
            `ADDR_INITY_LO: rd_val = iy_lo_ff;
            `ADDR_INITZ_HI: rd_val = iz_hi_ff;
            `ADDR_INITZ_LO: rd_val = iz_lo_ff;
            `ADDR_HYBRID: rd_val = {7'h00, hybrid_ff};
            `ADDR_INT_SRC: rd_val = {6'h00, flag_ff, 1'b0};
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_ff <= ap_valid && HWRITE_I;
            wr_addr_ff <= ap_addr;
            if (ap_valid && !HWRITE_I)
                rdata_ff <= {24'h00_0000, rd_val};
        end
    end

    assign HRDATA_O = rdata_ff;
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            HREADYOUT_O <= 1'b0;
            HRESP_O <= 1'b0;
        end
        else
        begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            cfg_ff <= `RST_BYTE;
            ths_hi_ff <= `RST_BYTE;
            ths_lo_ff <= `RST_BYTE;
            cnt_ff <= `RST_BYTE;
            ix_hi_ff <= `RST_BYTE;
            ix_lo_ff <= `RST_BYTE;
            iy_hi_ff <= `RST_BYTE;
            iy_lo_ff <= `RST_BYTE;
            iz_hi_ff <= `RST_BYTE;
            iz_lo_ff <= `RST_BYTE;
            hybrid_ff <= 1'b0;
        end
        else if (wr_pend_ff)
        begin
            case (wr_addr_ff)
                `ADDR_CFG: cfg_ff <= wb & 8'h7F;
                `ADDR_THS_HI: ths_hi_ff <= wb;
                `ADDR_THS_LO: ths_lo_ff <= wb;
                `ADDR_CNT: cnt_ff <= wb;
                `ADDR_INITX_HI: ix_hi_ff <= wb;
                `ADDR_INITX_LO: ix_lo_ff <= wb;
                `ADDR_INITY_HI: iy_hi_ff <= wb;
                `ADDR_INITY_LO: iy_lo_ff <= wb;
                `ADDR_INITZ_HI: iz_hi_ff <= wb;
                `ADDR_INITZ_LO: iz_lo_ff <= wb;
                `ADDR_HYBRID: hybrid_ff <= wb[0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // References and magnitude
    // ****************************************
    logic en, initm, updm, dbcntm;
    logic en_d_ff;
    logic en_rise;
    logic init_wr;
    logic init_upd_ff;
    axis_t rx_ff, ry_ff, rz_ff;
    axis_t ix, iy, iz;
    logic signed [16:0] dx, dy, dz;
    logic [35:0] mag2;
    logic [35:0] ths2;
    logic [14:0] ths;
    logic above;
    logic event_hit;
    logic step;

    assign en = cfg_ff[`CFG_EN];
    assign initm = cfg_ff[`CFG_INITM];
    assign updm = cfg_ff[`CFG_UPDM];
    assign dbcntm = ths_hi_ff[`THS_DBCNTM];
    assign ths = {ths_hi_ff[6:0], ths_lo_ff};
    assign ix = {ix_hi_ff, ix_lo_ff};
    assign iy = {iy_hi_ff, iy_lo_ff};
    assign iz = {iz_hi_ff, iz_lo_ff};
    assign en_rise = en && !en_d_ff;
    assign init_wr = wr_pend_ff && wr_addr_ff >= `ADDR_INITX_HI
        && wr_addr_ff <= `ADDR_INITZ_LO;
    assign dx = 17'(MAG_X_I) - 17'(rx_ff);
    assign dy = 17'(MAG_Y_I) - 17'(ry_ff);
    assign dz = 17'(MAG_Z_I) - 17'(rz_ff);
    // Squared compare avoids a square root
    assign mag2 = 36'(dx) * 36'(dx) + 36'(dy) * 36'(dy)
        + 36'(dz) * 36'(dz);
    assign ths2 = 36'(ths) * 36'(ths);
    assign above = mag2 > ths2;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            en_d_ff <= 1'b0;
            init_upd_ff <= 1'b0;
        end
        else
        begin
            en_d_ff <= en;
            init_upd_ff <= init_wr;
        end
    end

    // Load on enable rise; initm 0 takes the next sample
    logic pend_load_ff;
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            rx_ff <= 16'sh0000;
            ry_ff <= 16'sh0000;
            rz_ff <= 16'sh0000;
            pend_load_ff <= 1'b0;
        end
        else if (en_rise && initm)
        begin
            rx_ff <= ix;
            ry_ff <= iy;
            rz_ff <= iz;
            pend_load_ff <= 1'b0;
        end
        else if (en_rise)
            pend_load_ff <= 1'b1;
        else if (pend_load_ff && SAMPLE_VALID_I)
        begin
            rx_ff <= MAG_X_I;
            ry_ff <= MAG_Y_I;
            rz_ff <= MAG_Z_I;
            pend_load_ff <= 1'b0;
        end
        else if (en && initm && updm && init_upd_ff)
        begin
            rx_ff <= ix;
            ry_ff <= iy;
            rz_ff <= iz;
        end
        else if (event_hit && !updm)
        begin
            rx_ff <= MAG_X_I;
            ry_ff <= MAG_Y_I;
            rz_ff <= MAG_Z_I;
        end
        // Updm 1 holds references on events; with initm 1, init register writes still copy in
    end

    // ****************************************
    // Debounce
    // ****************************************
    logic half_ff;
    logic [7:0] dbc_ff;
    logic live_ff;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I || !en)
            half_ff <= 1'b0;
        else if (SAMPLE_VALID_I)
            half_ff <= !half_ff;
    end

    assign step = en && !pend_load_ff && SAMPLE_VALID_I
        && (!hybrid_ff || half_ff);
    assign event_hit = step && above && dbc_ff >= cnt_ff;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I || !en)
            dbc_ff <= 8'h00;
        else if (step)
        begin
            if (above)
                dbc_ff <= (dbc_ff == 8'hFF) ? dbc_ff : dbc_ff + 8'h01;
            else if (dbcntm)
                dbc_ff <= 8'h00;
            else if (dbc_ff != 8'h00)
                dbc_ff <= dbc_ff - 8'h01;
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I || !en)
            live_ff <= 1'b0;
        else if (step)
            live_ff <= event_hit;
    end

    // ****************************************
    // Flag and pins
    // ****************************************
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            flag_ff <= 1'b0;
        else if (!cfg_ff[`CFG_ELE])
            flag_ff <= step ? event_hit : live_ff;
        else if (event_hit)
            flag_ff <= 1'b1;
        else if (src_read)
            flag_ff <= 1'b0;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            IRQ_PIN_ONE_O <= 1'b0;
            IRQ_PIN_TWO_O <= 1'b0;
            WAKE_ACTIVITY_O <= 1'b0;
        end
        else
        begin
            IRQ_PIN_ONE_O <= flag_ff && cfg_ff[`CFG_INTEN]
                && cfg_ff[`CFG_ROUTE];
            IRQ_PIN_TWO_O <= flag_ff && cfg_ff[`CFG_INTEN]
                && !cfg_ff[`CFG_ROUTE];
            WAKE_ACTIVITY_O <= flag_ff && cfg_ff[`CFG_WAKE];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    a_latch_holds: assert property (cfg_ff[`CFG_ELE] && flag_ff
        && !src_read |=> flag_ff) else $error("latched flag dropped");
    a_latch_read: assert property (cfg_ff[`CFG_ELE] && flag_ff
        && src_read && !event_hit |=> !flag_ff)
        else $error("read kept flag");
    a_live_flag: assert property (!cfg_ff[`CFG_ELE]
        && !$past(cfg_ff[`CFG_ELE]) && step
        |=> flag_ff == $past(event_hit)) else $error("live flag wrong");
    a_pend_load: assert property (pend_load_ff && SAMPLE_VALID_I
        && !en_rise |=> rx_ff == $past(MAG_X_I) && !pend_load_ff)
        else $error("sample load missed");
    a_init_load: assert property (en_rise && initm
        |=> rx_ff == $past(ix)) else $error("init load missed");
    a_init_track: assert property (init_upd_ff && en && initm
        && updm && !en_rise && !pend_load_ff |=> rz_ff == $past(iz))
        else $error("init write not copied");
    a_upd_keep: assert property (event_hit && updm && !en_rise
        && !init_upd_ff |=> $stable(rx_ff)) else $error("ref moved");
    a_upd_load: assert property (event_hit && !updm && !en_rise
        |=> ry_ff == $past(MAG_Y_I)) else $error("ref not updated");
    a_dbc_clear: assert property (step && !above && dbcntm
        |=> dbc_ff == 8'h00) else $error("debounce not cleared");
    a_dbc_dec: assert property (step && !above && !dbcntm
        && dbc_ff != 8'h00 && en |=> dbc_ff == $past(dbc_ff) - 8'h01)
        else $error("debounce not decremented");
    a_pin_one: assert property (IRQ_PIN_ONE_O |-> !IRQ_PIN_TWO_O
        && $past(flag_ff) && $past(cfg_ff[`CFG_ROUTE]))
        else $error("pin one wrong");
    a_irq_off: assert property (!cfg_ff[`CFG_INTEN]
        |=> !IRQ_PIN_ONE_O && !IRQ_PIN_TWO_O) else $error("irq not gated");
    a_pin_follow: assert property (flag_ff && cfg_ff[`CFG_INTEN]
        |=> IRQ_PIN_ONE_O || IRQ_PIN_TWO_O) else $error("pin not raised");
    a_wake_gate: assert property (WAKE_ACTIVITY_O
        |-> $past(flag_ff) && $past(cfg_ff[`CFG_WAKE]))
        else $error("wake not gated");

    c_event: cover property (event_hit);
    c_latch_read: cover property (flag_ff && src_read);
    c_pin_two: cover property (IRQ_PIN_TWO_O);
    c_hybrid: cover property (hybrid_ff && event_hit);
    c_init_track: cover property (init_upd_ff && initm && updm);
endmodule : vecm_detector
`default_nettype wire

// File: verif/vecm_host.sv
// Host processor model: AHB-Lite master, single word transfers
// Assumes one slave whose ready output is the bus ready
`timescale 1ns/1ns
`default_nettype none
module vecm_host
(
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    import vecm_pkg::*;
    initial
    begin
        hsel_o = 1'b1;
        haddr_o = 32'h0000_0000;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0000_0000;
    end
    // One transfer; address is the register index times four
    task automatic xfer(input logic wr, input byte_t idx, input byte_t wd,
        output logic [31:0] rdat);
        @(posedge clk_i);
        htrans_o <= 2'h2;
        haddr_o <= {22'h00_0000, idx, 2'h0};
        hwrite_o <= wr;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_o <= 2'h0;
        hwdata_o <= {24'h00_0000, wd};
        do @(posedge clk_i); while (hready_i !== 1'b1);
        rdat = hrdata_i;
    endtask : xfer
endmodule : vecm_host
`default_nettype wire

// File: verif/vecm_detector_bench.sv
// Self-checking bench of the vector-magnitude detector
// Assumes the host model drives the register bus
`timescale 1ns/1ns
`default_nettype none
`include "vecm_defines.svh"
module vecm_detector_bench;
    import vecm_pkg::*;
    logic clk, rst, valid, one, two, wake, hrdy, hresp, hsel, hwr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    axis_t mx, my, mz;
    int err_count, checked;
    byte_t regs[4] = '{`ADDR_CFG, `ADDR_THS_HI, `ADDR_THS_LO, `ADDR_CNT};
    byte_t wval[4] = '{8'hFF, 8'hFF, 8'hA5, 8'hC3};
    byte_t rval[4] = '{8'h7F, 8'hFF, 8'hA5, 8'hC3};
    vecm_host i_vecm_host (.clk_i(clk), .hready_i(hrdy), .hrdata_i(hrdata),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwr),
        .hsize_o(hsize), .hwdata_o(hwdata));
    vecm_detector i_vecm_detector (.CLK_SYS_I(clk), .RST_I(rst),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwr),
        .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hrdy),
        .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
        .SAMPLE_VALID_I(valid), .MAG_X_I(mx), .MAG_Y_I(my), .MAG_Z_I(mz),
        .IRQ_PIN_ONE_O(one), .IRQ_PIN_TWO_O(two), .WAKE_ACTIVITY_O(wake));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic report_and_stop;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic wr(input byte_t a, input byte_t d);
        logic [31:0] r;
        i_vecm_host.xfer(1'b1, a, d, r);
    endtask : wr
    task automatic chk_rd(input byte_t a, input byte_t e);
        logic [31:0] r;
        i_vecm_host.xfer(1'b0, a, 8'h00, r);
        checked++;
        if ({hresp, r} !== {1'b0, 24'h00_0000, e})
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, {hresp, r},
                {1'b0, 24'h00_0000, e});
        end
    endtask : chk_rd
    // Pins in order one, two, wake
    task automatic chk_pins(input logic [2:0] e);
        checked++;
        if ({one, two, wake} !== e)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, {one, two, wake}, e);
        end
    endtask : chk_pins
    // Samples spaced well apart, as a slow sample rate
    task automatic smp(input axis_t x, input axis_t y, input axis_t z);
        @(posedge clk);
        valid <= 1'b1;
        mx <= x;
        my <= y;
        mz <= z;
        @(posedge clk);
        valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : smp
    // Disable, clear latched flag, threshold 10, then configure
    task automatic setup(input byte_t cfg, input byte_t hi, input byte_t cnt);
        logic [31:0] r;
        wr(`ADDR_CFG, 8'h00);
        i_vecm_host.xfer(1'b0, `ADDR_INT_SRC, 8'h00, r);
        wr(`ADDR_THS_HI, hi);
        wr(`ADDR_THS_LO, 8'h0A);
        wr(`ADDR_CNT, cnt);
        wr(`ADDR_CFG, cfg);
    endtask : setup
    // ****************************************
    // Clock, reset, watchdog
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        rst = 1'b1;
        valid = 1'b0;
        mx = 16'sh0000;
        my = 16'sh0000;
        mz = 16'sh0000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++)
            chk_rd(regs[k], 8'h00);
        chk_rd(8'h7F, 8'h00);
        for (int k = 0; k < 4; k++)
            wr(regs[k], wval[k]);
        for (int k = 0; k < 4; k++)
            chk_rd(regs[k], rval[k]);
        $display("TEST 1 done");
        setup(8'h7F, 8'h00, 8'h00);
        smp(0, 0, 5);
        chk_pins(3'b000);
        smp(0, 0, 20);
        chk_pins(3'b101);
        smp(0, 0, 5);
        chk_pins(3'b101);
        chk_rd(`ADDR_INT_SRC, 8'h02);
        chk_rd(`ADDR_INT_SRC, 8'h00);
        chk_pins(3'b000);
        $display("TEST 2 done");
        setup(8'h3A, 8'h00, 8'h00);
        smp(0, 0, 20);
        chk_pins(3'b010);
        smp(0, 0, 20);
        chk_pins(3'b010);
        smp(0, 0, 5);
        chk_pins(3'b000);
        wr(`ADDR_CFG, 8'h38);
        smp(0, 0, 20);
        chk_pins(3'b000);
        chk_rd(`ADDR_INT_SRC, 8'h02);
        wr(`ADDR_CFG, 8'h3A);
        wr(`ADDR_INITZ_LO, 8'h14);
        smp(0, 0, 20);
        chk_pins(3'b000);
        wr(`ADDR_INITZ_LO, 8'h00);
        $display("TEST 3 done");
        setup(8'h1A, 8'h00, 8'h00);
        smp(0, 0, 100);
        chk_pins(3'b000);
        smp(0, 0, 105);
        chk_pins(3'b000);
        smp(0, 0, 120);
        chk_pins(3'b010);
        wr(`ADDR_INITZ_LO, 8'h14);
        setup(8'h2A, 8'h00, 8'h00);
        smp(0, 0, 20);
        chk_pins(3'b000);
        smp(20, -20, 20);
        chk_pins(3'b010);
        smp(20, -20, 20);
        chk_pins(3'b000);
        wr(`ADDR_INITZ_LO, 8'h00);
        $display("TEST 4 done");
        for (int m = 0; m < 2; m++)
        begin
            setup(8'h3A, m ? 8'h80 : 8'h00, 8'h02);
            smp(0, 0, 20);
            smp(0, 0, 20);
            smp(0, 0, 5);
            smp(0, 0, 20);
            if (m)
                smp(0, 0, 20);
            chk_pins(3'b000);
            smp(0, 0, 20);
            chk_pins(3'b010);
        end
        $display("TEST 5 done");
        wr(`ADDR_HYBRID, 8'h01);
        chk_rd(`ADDR_HYBRID, 8'h01);
        setup(8'h3A, 8'h00, 8'h00);
        smp(0, 0, 20);
        chk_pins(3'b000);
        smp(0, 0, 20);
        chk_pins(3'b010);
        $display("TEST 6 done");
        report_and_stop();
    end
endmodule : vecm_detector_bench
`default_nettype wire
